// file: rtl/vdc_regs.svh
// Register offsets, reset values, field positions and fixed levels of the
// decoder control bank. Assumes inclusion by the design file.
`ifndef VDC_REGS_SVH
`define VDC_REGS_SVH

`define VDC_ADDR_INPUT_SEL    8'h00
`define VDC_ADDR_ANALOG       8'h01
`define VDC_ADDR_OPMODE       8'h02
`define VDC_ADDR_OUTPIN       8'h03
`define VDC_ADDR_STD_MASK     8'h04
`define VDC_ADDR_SOFT_RESET   8'h05
`define VDC_ADDR_KILLER       8'h06

`define VDC_RST_INPUT_SEL     8'h00
`define VDC_RST_ANALOG        8'h15
`define VDC_RST_OPMODE        8'h00
`define VDC_RST_OUTPIN        8'h01
`define VDC_RST_STD_MASK      8'hfc
`define VDC_RST_SOFT_RESET    8'h00
`define VDC_RST_KILLER        8'h10

// video_input_select
`define VDC_BIT_SVIDEO        0
`define VDC_BIT_CHAN_SEL      1
`define VDC_BIT_BLACK         3
// operating_mode_control
`define VDC_BIT_POWER_DOWN    0
`define VDC_BIT_LUMA_PEAK_OFF 1
`define VDC_BIT_SC_FREEZE     2
`define VDC_BIT_WHITE_PK_OFF  3
`define VDC_BIT_BURST_REF     6
// output_and_pin_control
`define VDC_BIT_CLK_OE        0
`define VDC_BIT_VBLANK_ON     1
`define VDC_BIT_SYNC_OE       2
`define VDC_BIT_PIXEL_OE      3
`define VDC_BIT_LOCK_SEL      4
`define VDC_BIT_GPL_DIR       5
`define VDC_BIT_GPL_LEVEL     6
`define VDC_BIT_PIN_SEL       7
// software_reset_control
`define VDC_BIT_SOFT_RESET    0

`define VDC_BLACK_NORMAL      8'h10
`define VDC_BLACK_EXTENDED    8'h01
`define VDC_UNMAPPED_READ     8'h00

`endif

// file: rtl/vdc_pkg.sv
// Types shared by the decoder control bank and its users.
// Assumes vdc_regs.svh is on the include path.
package vdc_pkg;

   typedef enum logic [2:0] {
      VDC_ST_IDLE = 3'b000,
      VDC_ST_DEV  = 3'b001,
      VDC_ST_SUB  = 3'b010,
      VDC_ST_WR   = 3'b011,
      VDC_ST_RD   = 3'b100
   } vdc_state_t;

   typedef struct packed {
      logic [1:0] offset_mode;
      logic [1:0] gain_mode;
      logic       burst_ref;
      logic [1:0] tv_vcr_mode;
      logic       white_peak_off;
      logic       luma_peak_off;
      logic       subcarrier_freeze;
      logic       power_down;
      logic [3:0] standard_mask;
      logic [1:0] killer_mode;
      logic [4:0] killer_threshold;
   } vdc_ctrl_t;

endpackage : vdc_pkg

// file: rtl/vdc_control_regs.sv
// Control register bank of the video decoder, reached over the two-wire
// serial host bus, plus the output steering that its fields drive.
// Assumes scl and sda_in already synchronous to mclk; the pad resolves sda.
// Operation
// - Composite from terminal A when channel bit 0, terminal B when 1.
// - S-video bit set: luma from terminal A, chroma from terminal B.
// - Black bit forces 10h normal range, 01h extended; syncs keep running.
// - Offset field: 00 off, 01 auto (reset), 10 reserved, 11 held.
// - Gain field: 00 fixed, 01 auto (reset), 10 reserved, 11 held.
// - Burst reference bit makes gain loop use colour burst; reset 0.
// - TV/VCR field: 00 auto, 01 reserved, 10 forced VCR, 11 forced TV.
// - Auto mode: unstable syncs select VCR, comb off, chroma trap on.
// - Two disable bits turn off white peak and luma peak processing.
// - Freeze bit stops subcarrier loop; genlock word carries frozen increment.
// - Power-down bit turns off converters and minimises clocking.
// - Pin select routes general purpose line at 0, vertical blanking at 1.
// - Bit 5 sets line direction, bit 6 its driven output level.
// - Lock select swaps PAL indicator and field id for lock flags.
// - Pixel bus driven only when both pixel and VBI enables are 1.
// - Sync enable bit drives sync, PAL, active video, field pins.
// - Vertical blanking bit turns the blanking signal off or on.
// - Clock enable bit drives sample clock; reset value 1.
// - Four mask bits exclude standards from autoswitch; reset value FCh.
// - Writing 1 to software reset reloads every register default.
// - Killer field: 00 auto, 01 reserved, 10 forced zero colour, 11 off.
// - Five-bit killer threshold: 11111 minimum, 10000 reset, 00000 maximum.
`include "vdc_regs.svh"
`timescale 1ns/1ps
`default_nettype none

module vdc_control_regs #(
   parameter logic [6:0] DEV_ADDR = 7'h2a,   // Arbitrary bus address
   parameter int         PHASE_W  = 22
) (
   input  wire logic                 mclk,
   input  wire logic                 reset_n,
   input  wire logic                 scl,
   input  wire logic                 sda_in,
   output var  logic                 sda_out,
   output var  logic                 sda_oe,
   input  wire logic [7:0]           input_terminal_a,
   input  wire logic [7:0]           input_terminal_b,
   input  wire logic                 extended_range,
   input  wire logic                 vbi_output_enable,
   input  wire logic                 sync_unstable,
   input  wire logic [PHASE_W-1:0]   phase_increment,
   input  wire logic                 pal_indicator,
   input  wire logic                 field_identifier,
   input  wire logic                 horizontal_lock_flag,
   input  wire logic                 vertical_lock_flag,
   input  wire logic                 vertical_blank_raw,
   input  wire logic                 blanking_or_gpio_pin_in,
   output var  logic                 blanking_or_gpio_pin_out,
   output var  logic                 blanking_or_gpio_pin_oe,
   output var  logic                 general_purpose_line_in,
   output var  logic                 vertical_blank_signal,
   output var  logic [7:0]           luma_sample,
   output var  logic [7:0]           chroma_sample,
   output var  logic                 svideo_mode,
   output var  logic                 black_active,
   output var  vdc_pkg::vdc_ctrl_t   ctrl,
   output var  logic                 vcr_mode_active,
   output var  logic                 comb_filter_enable,
   output var  logic                 chroma_trap_enable,
   output var  logic                 killer_force_zero,
   output var  logic [PHASE_W-1:0]   genlock_serial_out,
   output var  logic                 pixel_output_oe,
   output var  logic                 sync_outputs_oe,
   output var  logic                 sample_clock_oe,
   output var  logic                 vsync_pal_pin,
   output var  logic                 field_pin
);

   logic [7:0]          video_input_select;
   logic [7:0]          analog_front_end_control;
   logic [7:0]          operating_mode_control;
   logic [7:0]          output_and_pin_control;
   logic [7:0]          standard_autoswitch_mask;
   logic [7:0]          software_reset_control;
   logic [7:0]          colour_killer_control;

   vdc_pkg::vdc_state_t phase;
   logic [3:0]          bit_cnt;
   logic [7:0]          shift_in;
   logic [7:0]          tx_byte;
   logic [7:0]          sub_addr;
   logic                scl_q;
   logic                sda_q;
   logic                wr_en;
   logic [7:0]          wr_addr;
   logic [7:0]          wr_data;
   logic                soft_reset;

   logic                scl_rise;
   logic                scl_fall;
   logic                bus_start;
   logic                bus_stop;
   logic [7:0]          sel_composite;

   assign scl_rise  = scl & ~scl_q;
   assign scl_fall  = ~scl & scl_q;
   assign bus_start = scl & scl_q & sda_q & ~sda_in;
   assign bus_stop  = scl & scl_q & ~sda_q & sda_in;

   function automatic logic [7:0] rd_mux(input logic [7:0] a);
      case (a)
         `VDC_ADDR_INPUT_SEL:  rd_mux = video_input_select;
         `VDC_ADDR_ANALOG:     rd_mux = analog_front_end_control;
         `VDC_ADDR_OPMODE:     rd_mux = operating_mode_control;
         `VDC_ADDR_OUTPIN:     rd_mux = output_and_pin_control;
         `VDC_ADDR_STD_MASK:   rd_mux = standard_autoswitch_mask;
         `VDC_ADDR_SOFT_RESET: rd_mux = software_reset_control;
         `VDC_ADDR_KILLER:     rd_mux = colour_killer_control;
         default:              rd_mux = `VDC_UNMAPPED_READ;
      endcase
   endfunction : rd_mux

   // Serial bus line sampling
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         scl_q <= 1'b1;
         sda_q <= 1'b1;
      end else begin
         scl_q <= scl;
         sda_q <= sda_in;
      end
   end

   // Open-drain: the pad only ever pulls low, oe alone carries the data
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         sda_out <= 1'b0;
      end else begin
         sda_out <= 1'b0;
      end
   end

   // Byte engine: bits taken on scl rise, sda changed on scl fall
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         phase    <= vdc_pkg::VDC_ST_IDLE;
         bit_cnt  <= 4'h0;
         shift_in <= 8'h00;
         tx_byte  <= 8'h00;
         sub_addr <= 8'h00;
         sda_oe   <= 1'b0;
         wr_en    <= 1'b0;
         wr_addr  <= 8'h00;
         wr_data  <= 8'h00;
      end else begin
         wr_en <= 1'b0;
         if (bus_start) begin
            phase   <= vdc_pkg::VDC_ST_DEV;
            bit_cnt <= 4'h0;
            sda_oe  <= 1'b0;
         end else if (bus_stop) begin
            phase  <= vdc_pkg::VDC_ST_IDLE;
            sda_oe <= 1'b0;
         end else if (scl_rise && phase != vdc_pkg::VDC_ST_IDLE) begin
            if (bit_cnt != 4'h8) begin
               shift_in <= {shift_in[6:0], sda_in};
               bit_cnt  <= bit_cnt + 4'h1;
            end else begin
               bit_cnt <= 4'h0;
               // Host not acknowledging a read byte ends the read
               if (phase == vdc_pkg::VDC_ST_RD && sda_in) begin
                  phase <= vdc_pkg::VDC_ST_IDLE;
               end
            end
         end else if (scl_fall && phase != vdc_pkg::VDC_ST_IDLE) begin
            if (bit_cnt == 4'h8) begin
               case (phase)
                  vdc_pkg::VDC_ST_DEV: begin
                     if (shift_in[7:1] == DEV_ADDR) begin
                        sda_oe  <= 1'b1;
                        tx_byte <= rd_mux(sub_addr);
                        phase   <= shift_in[0] ? vdc_pkg::VDC_ST_RD : vdc_pkg::VDC_ST_SUB;
                     end else begin
                        phase <= vdc_pkg::VDC_ST_IDLE;
                     end
                  end
                  vdc_pkg::VDC_ST_SUB: begin
                     sub_addr <= shift_in;
                     sda_oe   <= 1'b1;
                     phase    <= vdc_pkg::VDC_ST_WR;
                  end
                  vdc_pkg::VDC_ST_WR: begin
                     wr_en    <= 1'b1;
                     wr_addr  <= sub_addr;
                     wr_data  <= shift_in;
                     sub_addr <= sub_addr + 8'h01;
                     sda_oe   <= 1'b1;
                  end
                  vdc_pkg::VDC_ST_RD: begin
                     sda_oe   <= 1'b0;
                     sub_addr <= sub_addr + 8'h01;
                     tx_byte  <= rd_mux(sub_addr + 8'h01);
                  end
                  default: begin
                     phase <= vdc_pkg::VDC_ST_IDLE;
                  end
               endcase
            end else if (phase == vdc_pkg::VDC_ST_RD) begin
               sda_oe <= ~tx_byte[3'd7 - bit_cnt[2:0]];
            end else begin
               sda_oe <= 1'b0;
            end
         end
      end
   end

   // Reload lands one cycle after the write, so bit 0 is seen then cleared
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         soft_reset <= 1'b0;
      end else begin
         soft_reset <= wr_en && wr_addr == `VDC_ADDR_SOFT_RESET
                       && wr_data[`VDC_BIT_SOFT_RESET];
      end
   end

   // Register file; unmapped writes are acknowledged and dropped
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         video_input_select       <= `VDC_RST_INPUT_SEL;
         analog_front_end_control <= `VDC_RST_ANALOG;
         operating_mode_control   <= `VDC_RST_OPMODE;
         output_and_pin_control   <= `VDC_RST_OUTPIN;
         standard_autoswitch_mask <= `VDC_RST_STD_MASK;
         software_reset_control   <= `VDC_RST_SOFT_RESET;
         colour_killer_control    <= `VDC_RST_KILLER;
      end else if (soft_reset) begin
         video_input_select       <= `VDC_RST_INPUT_SEL;
         analog_front_end_control <= `VDC_RST_ANALOG;
         operating_mode_control   <= `VDC_RST_OPMODE;
         output_and_pin_control   <= `VDC_RST_OUTPIN;
         standard_autoswitch_mask <= `VDC_RST_STD_MASK;
         software_reset_control   <= `VDC_RST_SOFT_RESET;
         colour_killer_control    <= `VDC_RST_KILLER;
      end else if (wr_en) begin
         case (wr_addr)
            `VDC_ADDR_INPUT_SEL:  video_input_select       <= wr_data;
            `VDC_ADDR_ANALOG:     analog_front_end_control <= wr_data;
            `VDC_ADDR_OPMODE:     operating_mode_control   <= wr_data;
            `VDC_ADDR_OUTPIN:     output_and_pin_control   <= wr_data;
            `VDC_ADDR_STD_MASK:   standard_autoswitch_mask <= wr_data;
            `VDC_ADDR_SOFT_RESET: software_reset_control   <= wr_data;
            `VDC_ADDR_KILLER:     colour_killer_control    <= wr_data;
            default: begin
            end
         endcase
      end
   end

   assign sel_composite = video_input_select[`VDC_BIT_CHAN_SEL] ? input_terminal_b
                                                               : input_terminal_a;

   // Video path selection and black forcing; sync pins are untouched by it
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         luma_sample   <= 8'h00;
         chroma_sample <= 8'h00;
         svideo_mode   <= 1'b0;
         black_active  <= 1'b0;
      end else begin
         svideo_mode  <= video_input_select[`VDC_BIT_SVIDEO];
         black_active <= video_input_select[`VDC_BIT_BLACK];
         if (video_input_select[`VDC_BIT_BLACK]) begin
            luma_sample <= extended_range ? `VDC_BLACK_EXTENDED
                                          : `VDC_BLACK_NORMAL;
         end else if (video_input_select[`VDC_BIT_SVIDEO]) begin
            luma_sample <= input_terminal_a;
         end else begin
            luma_sample <= sel_composite;
         end
         chroma_sample <= video_input_select[`VDC_BIT_SVIDEO] ? input_terminal_b
                                                             : 8'h00;
      end
   end

   // Mode fields to the datapath
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         ctrl               <= '0;
         vcr_mode_active    <= 1'b0;
         comb_filter_enable <= 1'b1;
         chroma_trap_enable <= 1'b0;
         killer_force_zero  <= 1'b0;
      end else begin
         ctrl.offset_mode       <= analog_front_end_control[3:2];
         ctrl.gain_mode         <= analog_front_end_control[1:0];
         ctrl.burst_ref         <= operating_mode_control[`VDC_BIT_BURST_REF];
         ctrl.tv_vcr_mode       <= operating_mode_control[5:4];
         ctrl.white_peak_off    <= operating_mode_control[`VDC_BIT_WHITE_PK_OFF];
         ctrl.luma_peak_off     <= operating_mode_control[`VDC_BIT_LUMA_PEAK_OFF];
         ctrl.subcarrier_freeze <= operating_mode_control[`VDC_BIT_SC_FREEZE];
         ctrl.power_down        <= operating_mode_control[`VDC_BIT_POWER_DOWN];
         ctrl.standard_mask     <= standard_autoswitch_mask[5:2];
         ctrl.killer_mode       <= colour_killer_control[6:5];
         ctrl.killer_threshold  <= colour_killer_control[4:0];
         killer_force_zero      <= colour_killer_control[6:5] == 2'b10;
         case (operating_mode_control[5:4])
            2'b10:   vcr_mode_active <= 1'b1;
            2'b11:   vcr_mode_active <= 1'b0;
            2'b00:   vcr_mode_active <= sync_unstable;
            default: vcr_mode_active <= vcr_mode_active;
         endcase
         comb_filter_enable <= ~vcr_mode_active;
         chroma_trap_enable <= vcr_mode_active;
      end
   end

   // Frozen loop keeps presenting the last increment it used
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         genlock_serial_out <= '0;
      end else if (!operating_mode_control[`VDC_BIT_SC_FREEZE]) begin
         genlock_serial_out <= phase_increment;
      end
   end

   // Output enables and shared pins
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         pixel_output_oe          <= 1'b0;
         sync_outputs_oe          <= 1'b0;
         sample_clock_oe          <= 1'b1;
         vertical_blank_signal    <= 1'b0;
         vsync_pal_pin            <= 1'b0;
         field_pin                <= 1'b0;
         blanking_or_gpio_pin_out <= 1'b0;
         blanking_or_gpio_pin_oe  <= 1'b0;
         general_purpose_line_in  <= 1'b0;
      end else begin
         pixel_output_oe <= output_and_pin_control[`VDC_BIT_PIXEL_OE]
                            & vbi_output_enable;
         sync_outputs_oe <= output_and_pin_control[`VDC_BIT_SYNC_OE];
         sample_clock_oe <= output_and_pin_control[`VDC_BIT_CLK_OE];
         vertical_blank_signal <= output_and_pin_control[`VDC_BIT_VBLANK_ON]
                                  & vertical_blank_raw;
         if (output_and_pin_control[`VDC_BIT_LOCK_SEL]) begin
            vsync_pal_pin <= horizontal_lock_flag;
            field_pin     <= vertical_lock_flag;
         end else begin
            vsync_pal_pin <= pal_indicator;
            field_pin     <= field_identifier;
         end
         if (output_and_pin_control[`VDC_BIT_PIN_SEL]) begin
            blanking_or_gpio_pin_out <= output_and_pin_control[`VDC_BIT_VBLANK_ON]
                                        & vertical_blank_raw;
            blanking_or_gpio_pin_oe  <= 1'b1;
         end else begin
            blanking_or_gpio_pin_out <= output_and_pin_control[`VDC_BIT_GPL_LEVEL];
            blanking_or_gpio_pin_oe  <= output_and_pin_control[`VDC_BIT_GPL_DIR];
         end
         general_purpose_line_in <= blanking_or_gpio_pin_in;
      end
   end

   property p_composite_sel;
      @(posedge mclk) disable iff (!reset_n)
      (!video_input_select[0] && !video_input_select[3])
         |=> luma_sample == ($past(video_input_select[1]) ? $past(input_terminal_b)
                                                         : $past(input_terminal_a));
   endproperty
   a_composite_sel: assert property (p_composite_sel)
      else $error("composite source mismatch");

   property p_svideo_sel;
      @(posedge mclk) disable iff (!reset_n)
      (video_input_select[0] && !video_input_select[3])
         |=> luma_sample == $past(input_terminal_a) && chroma_sample == $past(input_terminal_b);
   endproperty
   a_svideo_sel: assert property (p_svideo_sel)
      else $error("s-video routing wrong");

   property p_black_level;
      @(posedge mclk) disable iff (!reset_n)
      video_input_select[3] |=> luma_sample == ($past(extended_range) ? 8'h01 : 8'h10);
   endproperty
   a_black_level: assert property (p_black_level)
      else $error("black level wrong");

   property p_forced_vcr;
      @(posedge mclk) disable iff (!reset_n)
      (operating_mode_control[5:4] == 2'b10) [*2] |=> !comb_filter_enable && chroma_trap_enable;
   endproperty
   a_forced_vcr: assert property (p_forced_vcr)
      else $error("forced vcr not applied");

   property p_freeze_hold;
      @(posedge mclk) disable iff (!reset_n)
      operating_mode_control[2] |=> $stable(genlock_serial_out);
   endproperty
   a_freeze_hold: assert property (p_freeze_hold)
      else $error("frozen increment changed");

   property p_pixel_oe;
      @(posedge mclk) disable iff (!reset_n)
      pixel_output_oe |-> $past(output_and_pin_control[3]) && $past(vbi_output_enable);
   endproperty
   a_pixel_oe: assert property (p_pixel_oe)
      else $error("pixel bus enabled without both enables");

   property p_soft_reset;
      @(posedge mclk) disable iff (!reset_n)
      (wr_en && wr_addr == 8'h05 && wr_data[0]) |=> ##2
         standard_autoswitch_mask == 8'hfc && output_and_pin_control == 8'h01
         && colour_killer_control == 8'h10;
   endproperty
   a_soft_reset: assert property (p_soft_reset)
      else $error("software reset did not reload defaults");

   property p_reset_self_clear;
      @(posedge mclk) disable iff (!reset_n)
      soft_reset |=> software_reset_control == 8'h00 ##1 !soft_reset;
   endproperty
   a_reset_self_clear: assert property (p_reset_self_clear)
      else $error("software reset bit did not clear");

   property p_killer_zero;
      @(posedge mclk) disable iff (!reset_n)
      killer_force_zero |-> $past(colour_killer_control[6:5]) == 2'b10;
   endproperty
   a_killer_zero: assert property (p_killer_zero)
      else $error("killer forced in wrong mode");

endmodule : vdc_control_regs

`default_nettype wire

// file: tb/vdc_host.sv
// Two-wire bus host model: start, stop, bytes, single-register access.
// Assumes the bench resolves sda from all open-drain pulls.
`timescale 1ns/1ps
`default_nettype none
module vdc_host #(
   parameter logic [6:0] ADDR = 7'h2a
) (
   input  wire logic mclk,
   input  wire logic sda,
   output var  logic scl,
   output var  logic sda_low
);
   initial begin
      scl = 1'b1;
      sda_low = 1'b0;
   end
   task automatic wt();
      repeat (4) @(negedge mclk);
   endtask : wt
   // Data moves only while scl is low, so no false start or stop
   task automatic bx(input logic b, output logic r);
      sda_low = ~b;
      wt();
      scl = 1'b1;
      wt();
      r = sda;
      wt();
      scl = 1'b0;
   endtask : bx
   task automatic by(input logic [7:0] d, output logic [7:0] q, output logic nak);
      for (int i = 7; i >= 0; i--) bx(d[i], q[i]);
      bx(1'b1, nak);
   endtask : by
   // Start when stp is 0, stop when 1
   task automatic cond(input logic stp);
      sda_low = stp;
      wt();
      scl = 1'b1;
      wt();
      sda_low = ~stp;
      wt();
      if (!stp) scl = 1'b0;
   endtask : cond
   task automatic acc(input logic rd, input logic [7:0] sub, d,
                      output logic [7:0] q, output logic nak);
      logic [7:0] x;
      logic [2:0] n;
      cond(1'b0);
      by({ADDR, 1'b0}, x, n[0]);
      by(sub, x, n[1]);
      if (rd) begin
         cond(1'b0);
         by({ADDR, 1'b1}, x, n[2]);
         by(8'hff, q, x[0]);   // Released ninth bit is the closing NACK
      end else begin
         by(d, x, n[2]);
      end
      cond(1'b1);
      nak = |n;
   endtask : acc
endmodule : vdc_host
`default_nettype wire

// file: tb/vdc_control_regs_tb.sv
// Self-checking bench for the decoder control bank.
// Assumes vdc_host drives the bus; sda is resolved here.
`timescale 1ns/1ps
`default_nettype none
module vdc_control_regs_tb;
   logic mclk, reset_n, scl, sda_in, sda_low, sda_oe, extended_range, vbi_output_enable;
   logic sync_unstable, pal_indicator, field_identifier, horizontal_lock_flag;
   logic vertical_lock_flag, vertical_blank_raw, blanking_or_gpio_pin_in, pixel_output_oe;
   logic blanking_or_gpio_pin_out, blanking_or_gpio_pin_oe, vertical_blank_signal, nak;
   logic vcr_mode_active, comb_filter_enable, chroma_trap_enable, killer_force_zero;
   logic sync_outputs_oe, sample_clock_oe, vsync_pal_pin;
   logic svideo_mode, black_active, field_pin, general_purpose_line_in;
   logic [7:0] input_terminal_a, input_terminal_b, luma_sample, chroma_sample, q;
   logic [21:0] phase_increment, genlock_serial_out;
   vdc_pkg::vdc_ctrl_t ctrl;
   int bad_count, n_compared;
   logic [7:0] dflt [7] = '{8'h00, 8'h15, 8'h00, 8'h01, 8'hfc, 8'h00, 8'h10};
   assign sda_in = ~(sda_oe | sda_low);
   vdc_control_regs i_vdc_control_regs (.*, .sda_out());
   vdc_host i_vdc_host (.mclk(mclk), .sda(sda_in), .scl(scl), .sda_low(sda_low));
   task automatic chk(input logic [31:0] s, e);
      n_compared++;
      if (s !== e) begin
         bad_count++;
         $display("[FAIL] %0t got %h expected %h", $time, s, e);
      end
   endtask : chk
   task automatic wr(input logic [7:0] a, d);
      i_vdc_host.acc(1'b0, a, d, q, nak);
      chk(nak, 1'b0);
   endtask : wr
   task automatic rd(input logic [7:0] a, e);
      i_vdc_host.acc(1'b1, a, 8'h00, q, nak);
      chk(q, e);
   endtask : rd
   task automatic end_sim();
      if (bad_count == 0 && n_compared > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask : end_sim
   initial begin
      mclk = 1'b0;
      forever #5 mclk = ~mclk;
   end
   initial begin
      #800000;
      bad_count++;
      end_sim();
   end
   initial begin
      {reset_n, extended_range, pal_indicator, vertical_lock_flag} = '0;
      {vbi_output_enable, sync_unstable, horizontal_lock_flag, vertical_blank_raw} = '1;
      field_identifier = 1'b1;
      {blanking_or_gpio_pin_in, input_terminal_a, input_terminal_b} = 17'h03cc3;
      phase_increment = 22'h0001a5;
      repeat (20) @(negedge mclk);
      reset_n = 1'b1;
      chk({sample_clock_oe, pixel_output_oe, sync_outputs_oe}, 3'b100);
      for (int i = 0; i < 7; i++) rd(8'(i), dflt[i]);
      rd(8'h20, 8'h00);
      wr(8'h00, 8'h02);
      chk(luma_sample, 8'hc3);
      wr(8'h00, 8'h00);
      chk(luma_sample, 8'h3c);
      wr(8'h00, 8'h03);
      chk({luma_sample, chroma_sample}, 16'h3cc3);
      chk(svideo_mode, 1'b1);
      wr(8'h00, 8'h08);
      chk(luma_sample, 8'h10);
      chk(black_active, 1'b1);
      extended_range = 1'b1;
      repeat (3) @(negedge mclk);
      chk(luma_sample, 8'h01);
      wr(8'h02, 8'h00);
      chk({vcr_mode_active, comb_filter_enable, chroma_trap_enable}, 3'b101);
      wr(8'h02, 8'h30);
      chk(vcr_mode_active, 1'b0);
      wr(8'h02, 8'h6b);
      chk({ctrl.burst_ref, ctrl.tv_vcr_mode, ctrl.white_peak_off, ctrl.luma_peak_off,
           ctrl.power_down, vcr_mode_active}, 7'h6f);
      wr(8'h02, 8'h04);
      phase_increment = 22'h2aaaa;
      repeat (3) @(negedge mclk);
      chk(genlock_serial_out, 22'h0001a5);
      wr(8'h02, 8'h00);
      chk(genlock_serial_out, 22'h2aaaa);
      wr(8'h03, 8'h0d);
      chk({pixel_output_oe, sync_outputs_oe}, 2'b11);
      vbi_output_enable = 1'b0;
      repeat (3) @(negedge mclk);
      chk(pixel_output_oe, 1'b0);
      wr(8'h03, 8'h60);
      chk({blanking_or_gpio_pin_out, blanking_or_gpio_pin_oe, sample_clock_oe}, 3'b110);
      chk(general_purpose_line_in, 1'b0);
      wr(8'h03, 8'h83);
      chk({blanking_or_gpio_pin_out, vertical_blank_signal}, 2'b11);
      wr(8'h03, 8'h11);
      chk({vsync_pal_pin, field_pin}, 2'b10);
      wr(8'h04, 8'h00);
      chk(ctrl.standard_mask, 4'h0);
      wr(8'h06, 8'h5f);
      chk({killer_force_zero, ctrl.killer_mode, ctrl.killer_threshold}, 8'hdf);
      wr(8'h05, 8'h01);
      rd(8'h05, 8'h00);
      rd(8'h06, 8'h10);
      chk({vsync_pal_pin, field_pin}, 2'b01);
      end_sim();
   end
endmodule : vdc_control_regs_tb
`default_nettype wire
